// ---- hdl/msg_pend_i2c.sv ----
// i2c client that streams queued messages and drives the pending line
// How it works
// - pending line low while messages wait
// - edge mode: release after id acked, next loaded
// - edge mode: at stop, low again if queue nonempty
// - continuous read keeps streaming message bytes
// - send id 255 when nothing valid remains
// - level mode: low while more messages queued
// - level mode: release after last id acked
// - config picks mode and can force level
// - sda and scl only pulled low or released
// - stretch scl while busy or byte not ready
// - stretch never beyond 2 ms
// - pending line is active-low open drain
// - exactly one of two modes selected
`timescale 1ns/1ps
module msg_pend_i2c #(
  parameter logic [6:0] DEV_ADDR = msg_pend_pkg::DEFAULT_ADDR,
  parameter int unsigned STRETCH_CYCLES = msg_pend_pkg::STRETCH_MAX_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // i2c pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // message-pending pin, active-low open drain
  output logic msg_pending_n_o,
  output logic msg_pending_n_oe,
  // comm_config_object settings
  input wire logic cfg_mode,
  input wire logic cfg_force_en,
  input wire logic cfg_force_level,
  // message_processor_object head byte, show-ahead
  input wire logic [7:0] msg_count,
  input wire logic head_valid,
  input wire logic [7:0] head_data,
  input wire logic head_is_id,
  output logic head_take,
  // internal busy indication
  input wire logic core_busy,
  // link status
  output logic link_active,
  output logic bus_stop
);
  ////////////////////////////////////////////////////////////////////////////////
  // pin sampling and bus conditions
  logic [1:0] pins_sync;
  logic scl_s, sda_s, scl_prev, sda_prev;

  sync2 #(.WIDTH(2)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in({scl_i, sda_i}),
    .sync_out(pins_sync)
  );

  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_prev;
  wire scl_fall = ~scl_s & scl_prev;
  wire start_det = scl_s & scl_prev & sda_prev & ~sda_s;
  wire stop_det = scl_s & scl_prev & ~sda_prev & sda_s;

  ////////////////////////////////////////////////////////////////////////////////
  // link state machine
  msg_pend_pkg::link_state_t state, next_state;
  logic [7:0] shreg;
  logic [2:0] bit_cnt;
  logic rw;
  logic host_ack;
  logic skip_fall;
  logic cur_is_id;
  logic id_hold;
  logic released;
  logic pend_q;
  logic [msg_pend_pkg::STRETCH_W-1:0] stretch_cnt;

  wire stretch_limit = stretch_cnt >= STRETCH_CYCLES[msg_pend_pkg::STRETCH_W-1:0];
  wire msgs_waiting = msg_count != 8'h00;
  wire addr_hit = shreg[msg_pend_pkg::ADDR_MSB:1] == DEV_ADDR;
  wire byte_done = scl_fall && bit_cnt == msg_pend_pkg::LAST_BIT;
  wire in_load = state == msg_pend_pkg::ST_LOAD;
  wire active = state != msg_pend_pkg::ST_IDLE;
  // a byte is loaded from the queue head, or 255 when nothing valid is left or the stretch limit is reached
  wire nothing_left = !head_valid && !msgs_waiting && !id_hold;
  wire load_head = in_load && head_valid && !core_busy;
  wire load_invalid = in_load && !load_head && (nothing_left || stretch_limit);
  wire load_done = load_head || load_invalid;
  wire [7:0] load_byte = load_head ? head_data : msg_pend_pkg::INVALID_ID;
  // the loaded byte follows an acknowledged report id
  wire id_passed = load_done && cur_is_id;

  // hold scl low while the next byte is not ready or the core is busy
  wire want_stretch = in_load || (core_busy && active && !scl_s);
  wire stretch_on = want_stretch && !stretch_limit;

  always_comb begin
    next_state = state;
    if (start_det) begin
      next_state = msg_pend_pkg::ST_ADDR;
    end else if (stop_det) begin
      next_state = msg_pend_pkg::ST_IDLE;
    end else begin
      unique case (state)
        msg_pend_pkg::ST_IDLE: next_state = state;
        msg_pend_pkg::ST_ADDR: begin
          if (byte_done) begin
            next_state = addr_hit ? msg_pend_pkg::ST_ACK : msg_pend_pkg::ST_IDLE;
          end
        end
        msg_pend_pkg::ST_ACK: begin
          if (scl_fall) begin
            next_state = rw ? msg_pend_pkg::ST_LOAD : msg_pend_pkg::ST_RX;
          end
        end
        msg_pend_pkg::ST_LOAD: begin
          if (load_done) begin
            next_state = msg_pend_pkg::ST_TX;
          end
        end
        msg_pend_pkg::ST_TX: begin
          if (byte_done) begin
            next_state = msg_pend_pkg::ST_MACK;
          end
        end
        msg_pend_pkg::ST_MACK: begin
          if (scl_fall) begin
            // a nack ends the read; only a following stop or start is watched
            next_state = host_ack ? msg_pend_pkg::ST_LOAD : msg_pend_pkg::ST_IDLE;
          end
        end
        msg_pend_pkg::ST_RX: begin
          if (byte_done) begin
            next_state = msg_pend_pkg::ST_RXACK;
          end
        end
        msg_pend_pkg::ST_RXACK: begin
          if (scl_fall) begin
            next_state = msg_pend_pkg::ST_RX;
          end
        end
        default: next_state = msg_pend_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= msg_pend_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shifter, bit counter and acknowledge capture
  wire shift_in = (state == msg_pend_pkg::ST_ADDR || state == msg_pend_pkg::ST_RX) && scl_rise;
  wire shift_out = state == msg_pend_pkg::ST_TX && scl_fall && bit_cnt != msg_pend_pkg::LAST_BIT;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shreg <= 8'h00;
    end else if (load_done) begin
      shreg <= load_byte;
    end else if (shift_in) begin
      shreg <= {shreg[6:0], sda_s};
    end else if (shift_out) begin
      shreg <= {shreg[6:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt <= 3'h0;
    end else if (start_det || load_done || (state == msg_pend_pkg::ST_RXACK && scl_fall)) begin
      bit_cnt <= 3'h0;
    end else if ((state == msg_pend_pkg::ST_ADDR || state == msg_pend_pkg::ST_RX
                  || state == msg_pend_pkg::ST_TX) && scl_fall && !skip_fall) begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rw <= 1'b0;
      host_ack <= 1'b0;
      skip_fall <= 1'b0;
    end else begin
      // the scl fall that follows a start carries no bit
      if (start_det || scl_fall) begin
        skip_fall <= start_det;
      end
      if (state == msg_pend_pkg::ST_ADDR && byte_done) begin
        rw <= shreg[msg_pend_pkg::RW_BIT];
      end
      if (state == msg_pend_pkg::ST_MACK && scl_rise) begin
        host_ack <= ~sda_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clock stretch timer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stretch_cnt <= '0;
    end else if (!want_stretch) begin
      stretch_cnt <= '0;
    end else if (!stretch_limit) begin
      stretch_cnt <= stretch_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pending-line tracking
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_is_id <= 1'b0;
      id_hold <= 1'b0;
      released <= 1'b0;
    end else if (stop_det) begin
      cur_is_id <= 1'b0;
      id_hold <= 1'b0;
      released <= 1'b0;
    end else if (load_done) begin
      cur_is_id <= load_head && head_is_id;
      id_hold <= load_head && head_is_id;
      if (id_passed) begin
        released <= 1'b1;
      end
    end
  end

  // edge mode stays released until stop; level mode follows the queue
  wire pend_edge = (msgs_waiting || id_hold) && !released;
  wire pend_level = msgs_waiting || id_hold;
  wire pend_mode = (cfg_mode == msg_pend_pkg::MODE_LEVEL) ? pend_level : pend_edge;
  wire next_pend = cfg_force_en ? !cfg_force_level : pend_mode;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= next_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // open-drain drivers
  wire tx_drive = state == msg_pend_pkg::ST_TX && !shreg[7];
  wire ack_drive = state == msg_pend_pkg::ST_ACK || state == msg_pend_pkg::ST_RXACK;

  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe = tx_drive || ack_drive;
  assign scl_oe = stretch_on;
  assign msg_pending_n_o = 1'b0;
  assign msg_pending_n_oe = pend_q;
  assign head_take = load_head;
  assign link_active = active;
  assign bus_stop = stop_det;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence id_acked_s;
    id_passed && !cfg_force_en;
  endsequence

  sequence queue_empty_s;
    !msgs_waiting && !cfg_force_en;
  endsequence

  pend_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (msgs_waiting && !cfg_force_en && cfg_mode == msg_pend_pkg::MODE_LEVEL)
      |=> msg_pending_n_oe)
    else $error("pending line not low with messages queued");

  edge_release_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cfg_mode == msg_pend_pkg::MODE_EDGE) throughout (id_acked_s ##1 (!stop_det && !cfg_force_en))
      |=> !msg_pending_n_oe)
    else $error("edge mode line not released after id ack");

  stop_relow_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (stop_det && msgs_waiting && !cfg_force_en ##1 msgs_waiting && !cfg_force_en)
      |=> msg_pending_n_oe)
    else $error("line not low again after stop with queue");

  stop_high_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (stop_det ##1 queue_empty_s[*2]) |-> !msg_pending_n_oe)
    else $error("line low after stop with empty queue");

  level_last_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cfg_mode == msg_pend_pkg::MODE_LEVEL ##0 id_acked_s ##1 queue_empty_s ##0 !id_hold)
      |=> !msg_pending_n_oe)
    else $error("level mode line not released after last id");

  invalid_id_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (in_load && nothing_left && !start_det && !stop_det)
      |=> shreg == msg_pend_pkg::INVALID_ID && state == msg_pend_pkg::ST_TX)
    else $error("invalid report id not sent");

  force_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cfg_force_en |=> msg_pending_n_oe == !$past(cfg_force_level))
    else $error("forced level not applied");

  stretch_bound_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    scl_oe |-> stretch_cnt < STRETCH_CYCLES[msg_pend_pkg::STRETCH_W-1:0])
    else $error("clock stretch past its limit");

  sda_owner_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sda_oe |-> (state == msg_pend_pkg::ST_TX || ack_drive))
    else $error("sda driven outside a drive phase");

  continue_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == msg_pend_pkg::ST_MACK && host_ack && scl_fall && !start_det && !stop_det)
      |=> in_load ##0 scl_oe)
    else $error("acked read did not fetch next byte");
endmodule // msg_pend_i2c

// ---- include/msg_pend_pkg.sv ----
// shared constants and types of the message-pending i2c client
package msg_pend_pkg;
  // link states, gray coded along the read path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_ACK   = 3'b011,
    ST_LOAD  = 3'b010,
    ST_TX    = 3'b110,
    ST_MACK  = 3'b111,
    ST_RX    = 3'b101,
    ST_RXACK = 3'b100
  } link_state_t;

  // pending-line modes
  localparam logic MODE_EDGE = 1'b0;
  localparam logic MODE_LEVEL = 1'b1;

  // report id returned when no valid message remains
  localparam logic [7:0] INVALID_ID = 8'hff;
  localparam logic [6:0] DEFAULT_ADDR = 7'h2a;

  // bit and byte layout of the link
  localparam int BITS_PER_BYTE = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int ADDR_MSB = 7;
  localparam int RW_BIT = 0;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STRETCH_MAX_NS = 2_000_000;
  localparam int STRETCH_TYP_NS = 350_000;
  localparam int STRETCH_MAX_CYC = STRETCH_MAX_NS / CLK_PERIOD_NS;
  localparam int STRETCH_W = 18;
  localparam int SYNC_RESET_VAL = 1;
endpackage

// ---- hdl/sync2.sv ----
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // asynchronous input and synchronised output
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // idle i2c lines rest high, so both stages reset high
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '1;
      sync_out <= '1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // sync2

// ---- verification/i2c_host_model.sv ----
// behavioural i2c host that reads queued messages
`timescale 1ns/1ps
module i2c_host_model (
  // resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // open-drain pulls, high pulls the line low
  output logic scl_oe,
  output logic sda_oe
);
  int stretch_ns = 0;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // one bit at 125 ns: data set while scl low, sampled mid high phase
  task automatic xfer(input logic b, output logic r);
    int n;
    sda_oe = !b;
    #31.25;
    scl_oe = 1'b0;
    n = 0;
    while (!scl && n < 100000) begin
      #1;
      n++;
    end
    if (n > stretch_ns) stretch_ns = n;
    #31.25;
    r = sda;
    #31.25;
    scl_oe = 1'b1;
    #31.25;
  endtask
  task automatic start();
    sda_oe = 1'b0;
    scl_oe = 1'b0;
    #62.5;
    sda_oe = 1'b1;
    #62.5;
    scl_oe = 1'b1;
    #31.25;
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    #31.25;
    scl_oe = 1'b0;
    #62.5;
    sda_oe = 1'b0;
    #125;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(d[i], r);
    xfer(1'b1, r);
    ack = !r;
  endtask
  // ack low keeps a continuous read going, nack ends it
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(!ack, r);
  endtask
endmodule // i2c_host_model

// ---- verification/i2c_message_pending_signaling_test.sv ----
// self-checking bench for the message-pending i2c client
`timescale 1ns/1ps
module i2c_message_pending_signaling_test;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cfg_mode = msg_pend_pkg::MODE_EDGE;
  logic cfg_force_en = 1'b0;
  logic cfg_force_level = 1'b1;
  logic [7:0] msg_count = 8'h00;
  logic head_valid = 1'b0;
  logic [7:0] head_data = 8'h00;
  logic head_is_id = 1'b0;
  logic core_busy = 1'b0;
  logic head_take, scl_o, scl_oe, sda_o, sda_oe, pend_o, pend_oe, h_scl_oe, h_sda_oe;
  logic [7:0] q_data[$];
  logic q_id[$];
  int errors = 0;
  int compares = 0;
  // open-drain lines with pull-ups
  wire logic scl = !(scl_oe || h_scl_oe);
  wire logic sda = !(sda_oe || h_sda_oe);
  wire logic pend = !pend_oe;
  always #5 sys_clk = ~sys_clk;
  msg_pend_i2c #(.STRETCH_CYCLES(50)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .msg_pending_n_o(pend_o), .msg_pending_n_oe(pend_oe),
    .cfg_mode(cfg_mode), .cfg_force_en(cfg_force_en), .cfg_force_level(cfg_force_level),
    .msg_count(msg_count), .head_valid(head_valid), .head_data(head_data),
    .head_is_id(head_is_id), .head_take(head_take), .core_busy(core_busy),
    .link_active(), .bus_stop());
  i2c_host_model host (.scl(scl), .sda(sda), .scl_oe(h_scl_oe), .sda_oe(h_sda_oe));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // message source, show-ahead head byte
  task automatic refresh();
    head_valid = q_data.size() > 0;
    head_data = head_valid ? q_data[0] : 8'h00;
    head_is_id = head_valid ? q_id[0] : 1'b0;
  endtask
  task automatic push_msg(input logic [7:0] id, input logic [7:0] data);
    @(posedge sys_clk);
    #1;
    q_data.push_back(id);
    q_id.push_back(1'b1);
    q_data.push_back(data);
    q_id.push_back(1'b0);
    msg_count = msg_count + 8'h01;
    refresh();
  endtask
  always @(posedge sys_clk) begin
    if (head_take === 1'b1) begin
      #1;
      if (q_id[0]) msg_count = msg_count - 8'h01;
      void'(q_data.pop_front());
      void'(q_id.pop_front());
      refresh();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic open_read();
    logic ack;
    host.start();
    host.wr_byte({msg_pend_pkg::DEFAULT_ADDR, 1'b1}, ack);
    check({7'h00, ack}, 8'h01, "address ack");
  endtask
  task automatic rd_chk(input logic ack, input logic [7:0] exp, input string what);
    logic [7:0] d;
    host.rd_byte(ack, d);
    check(d, exp, what);
  endtask
  task automatic pend_chk(input logic exp, input string what);
    repeat (20) @(posedge sys_clk);
    #1;
    check({7'h00, pend}, {7'h00, exp}, what);
  endtask
  task automatic t_edge();
    push_msg(8'h01, 8'h11);
    push_msg(8'h02, 8'h22);
    pend_chk(1'b0, "edge pending");
    open_read();
    rd_chk(1'b1, 8'h01, "first id");
    pend_chk(1'b1, "edge release");
    rd_chk(1'b1, 8'h11, "first data");
    rd_chk(1'b1, 8'h02, "second id");
    rd_chk(1'b1, 8'h22, "second data");
    rd_chk(1'b0, msg_pend_pkg::INVALID_ID, "empty id");
    host.stop();
    pend_chk(1'b1, "edge stop empty");
    $display("test edge done");
  endtask
  task automatic t_nack();
    push_msg(8'h03, 8'h33);
    push_msg(8'h04, 8'h44);
    open_read();
    rd_chk(1'b1, 8'h03, "third id");
    rd_chk(1'b0, 8'h33, "third data");
    host.stop();
    pend_chk(1'b0, "relow after nack");
    open_read();
    rd_chk(1'b1, 8'h04, "fourth id");
    rd_chk(1'b0, 8'h44, "fourth data");
    host.stop();
    pend_chk(1'b1, "drained");
    $display("test nack done");
  endtask
  task automatic t_level();
    cfg_mode = msg_pend_pkg::MODE_LEVEL;
    push_msg(8'h05, 8'h55);
    push_msg(8'h06, 8'h66);
    open_read();
    rd_chk(1'b1, 8'h05, "fifth id");
    pend_chk(1'b0, "level held");
    rd_chk(1'b1, 8'h55, "fifth data");
    rd_chk(1'b1, 8'h06, "sixth id");
    pend_chk(1'b1, "level release");
    rd_chk(1'b0, 8'h66, "sixth data");
    host.stop();
    $display("test level done");
  endtask
  task automatic t_force();
    push_msg(8'h07, 8'h77);
    cfg_force_en = 1'b1;
    cfg_force_level = 1'b1;
    pend_chk(1'b1, "forced high");
    cfg_force_level = 1'b0;
    cfg_mode = msg_pend_pkg::MODE_EDGE;
    pend_chk(1'b0, "forced low");
    cfg_force_en = 1'b0;
    pend_chk(1'b0, "unforced");
    $display("test force done");
  endtask
  task automatic t_stretch();
    // busy before the frame, so the head byte cannot be loaded at the ack fall
    @(posedge sys_clk);
    #1;
    core_busy = 1'b1;
    open_read();
    host.stretch_ns = 0;
    rd_chk(1'b0, msg_pend_pkg::INVALID_ID, "stretch limit id");
    check({7'h00, host.stretch_ns > 0}, 8'h01, "stretched");
    check({7'h00, host.stretch_ns <= 560}, 8'h01, "stretch bound");
    host.stop();
    @(posedge sys_clk);
    #1;
    core_busy = 1'b0;
    open_read();
    rd_chk(1'b1, 8'h07, "id after busy");
    rd_chk(1'b0, 8'h77, "data after busy");
    host.stop();
    check({5'h00, scl_o, sda_o, pend_o}, 8'h00, "drive only low");
    $display("test stretch done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    t_edge();
    t_nack();
    t_level();
    t_force();
    t_stretch();
    final_report();
  end
  initial begin
    #200_000;
    errors++;
    $display("ERROR %0t: watchdog expired", $time);
    final_report();
  end
endmodule // i2c_message_pending_signaling_test
